// [rtl/stepper_phase_sequencer.sv]
// phase distribution logic for a two-phase unipolar stepper driver
// assumes step clock and control levels come from pins, asynchronous to core_clk
// Function
// - phase pattern advances only on step clock rising edges, never falling
// - excitation select low gives full-step, high gives half-step
// - direction select low steps forward, high steps in reverse
// - while reset is low, sequencer held and all four phases off
// - after reset the first winding gate output comes on in the same cycle as winding2_rev
// - reset state energizes winding1 forward and winding2 reverse
// - half-step inserts single-winding states, drive off a quarter of time
// - excitation select is sampled on the step clock rising edge
`timescale 1ns/1ps
module stepper_phase_sequencer
  import stepper_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic step_clk,
  input wire logic excitation_select,
  input wire logic direction_select,
  output logic first_coil_switch,
  output logic winding2_fwd,
  output logic winding1_rev,
  output logic winding2_rev
);

  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic step_prev_r;
  logic [2:0] pos_r;
  logic [2:0] pos_nxt;
  logic [3:0] phase_nxt;
  logic step_rise;
  logic half_mode;

  // two-flop synchronisers for the three pin inputs; the step bit resets high
  // like its pulled-up pin, so a clock already high at release is no step
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_r <= 3'h1;
      sync2_r <= 3'h1;
    end
    else
    begin
      sync1_r <= {direction_select, excitation_select, step_clk};
      sync2_r <= sync1_r;
    end
  end

  // previous synchronised step level for rising edge detection
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      step_prev_r <= 1'b1;
    else
      step_prev_r <= sync2_r[0];
  end

  assign step_rise = sync2_r[0] & ~step_prev_r;
  assign half_mode = sync2_r[1];

  // position on an eight-entry ring; full-step uses only even positions
  always_comb
  begin
    pos_nxt = pos_r;
    if (half_mode)
    begin
      if (sync2_r[2])
        pos_nxt = pos_r - POS_HALF_STEP;
      else
        pos_nxt = pos_r + POS_HALF_STEP;
    end
    else
    begin
      // snap an odd position to even when entering full-step
      if (sync2_r[2])
        pos_nxt = (pos_r[0] ? pos_r - POS_HALF_STEP : pos_r - POS_FULL_STEP);
      else
        pos_nxt = (pos_r[0] ? pos_r + POS_HALF_STEP : pos_r + POS_FULL_STEP);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      pos_r <= POS_RESET;
    else if (step_rise)
      pos_r <= pos_nxt;
  end

  // even: two windings, odd: one winding
  always_comb
  begin
    case (pos_nxt)
      3'h0: phase_nxt = PHASE_AT_RESET;
      3'h1: phase_nxt = 4'h8;
      3'h2: phase_nxt = 4'hC;
      3'h3: phase_nxt = 4'h4;
      3'h4: phase_nxt = 4'h6;
      3'h5: phase_nxt = 4'h2;
      3'h6: phase_nxt = 4'h3;
      3'h7: phase_nxt = 4'h1;
      default: phase_nxt = PHASE_OFF;
    endcase
  end

  // start flag: set on the first clock after reset release, never cleared
  logic started_r;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      started_r <= 1'b0;
    else
      started_r <= 1'b1;
  end

  // outputs cut off during reset, then open at the start state
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      {first_coil_switch, winding2_fwd, winding1_rev, winding2_rev} <= PHASE_OFF;
    else if (!started_r)
      {first_coil_switch, winding2_fwd, winding1_rev, winding2_rev} <= PHASE_AT_RESET;
    else if (step_rise)
      {first_coil_switch, winding2_fwd, winding1_rev, winding2_rev} <= phase_nxt;
  end

  // sequencer checks
  phase_exclusive_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !(first_coil_switch && winding1_rev) && !(winding2_fwd && winding2_rev))
    else $error("opposing winding halves on together");

  start_state_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(started_r) |-> first_coil_switch && winding2_rev && !winding2_fwd && !winding1_rev)
    else $error("start state wrong");

  start_pos_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(started_r) |-> pos_r == POS_RESET)
    else $error("start position wrong");

  outs_dark_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !started_r |->
      {first_coil_switch, winding2_fwd, winding1_rev, winding2_rev} == PHASE_OFF)
    else $error("outputs on before start");

  never_dark_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    started_r |->
      {first_coil_switch, winding2_fwd, winding1_rev, winding2_rev} != PHASE_OFF)
    else $error("all outputs off after start");

  hold_no_edge_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    started_r && $past(started_r) && !$past(step_rise) |-> $stable(pos_r))
    else $error("position moved without step edge");

  out_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    started_r && $past(started_r) && !$past(step_rise) |->
      $stable({first_coil_switch, winding2_fwd, winding1_rev, winding2_rev}))
    else $error("outputs moved without step edge");

  step_moves_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    step_rise |=> !$stable({first_coil_switch, winding2_fwd, winding1_rev, winding2_rev}))
    else $error("step edge left outputs unchanged");

  full_even_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    step_rise && !half_mode |=> !pos_r[0])
    else $error("full-step landed on half position");

  full_fwd_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    step_rise && !half_mode && !sync2_r[2] && !pos_r[0] |=>
      pos_r == $past(pos_r) + POS_FULL_STEP)
    else $error("forward full step wrong");

  full_back_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    step_rise && !half_mode && sync2_r[2] && !pos_r[0] |=>
      pos_r == $past(pos_r) - POS_FULL_STEP)
    else $error("reverse full step wrong");

  half_one_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    step_rise && half_mode && !sync2_r[2] |=> pos_r == $past(pos_r) + 3'h1)
    else $error("forward half step wrong");

  half_back_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    step_rise && half_mode && sync2_r[2] |=> pos_r == $past(pos_r) - 3'h1)
    else $error("reverse half step wrong");

  snap_fwd_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    step_rise && !half_mode && !sync2_r[2] && pos_r[0] |=>
      pos_r == $past(pos_r) + POS_HALF_STEP)
    else $error("forward snap to full position wrong");

  snap_back_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    step_rise && !half_mode && sync2_r[2] && pos_r[0] |=>
      pos_r == $past(pos_r) - POS_HALF_STEP)
    else $error("reverse snap to full position wrong");

  two_on_even_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    step_rise ##1 !pos_r[0] |-> $countones({first_coil_switch, winding2_fwd,
      winding1_rev, winding2_rev}) == 2)
    else $error("full position not two windings");

  odd_one_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    step_rise ##1 pos_r[0] |-> $countones({first_coil_switch, winding2_fwd,
      winding1_rev, winding2_rev}) == 1)
    else $error("half position not one winding");

  started_once_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    started_r |=> started_r)
    else $error("start flag dropped");

  // main scenarios
  step_fwd_c: cover property (@(posedge core_clk) disable iff (!rst_n)
    step_rise && !sync2_r[2]);
  step_rev_c: cover property (@(posedge core_clk) disable iff (!rst_n)
    step_rise && sync2_r[2]);
  half_wrap_c: cover property (@(posedge core_clk) disable iff (!rst_n)
    step_rise && half_mode && pos_r == 3'h7);
  full_snap_c: cover property (@(posedge core_clk) disable iff (!rst_n)
    step_rise && !half_mode && pos_r[0]);
  full_rev_c: cover property (@(posedge core_clk) disable iff (!rst_n)
    step_rise && !half_mode && sync2_r[2] && !pos_r[0]);

endmodule : stepper_phase_sequencer

// [shared/stepper_pkg.sv]
// constants for the stepper phase sequencer
// assumes a single 40 MHz core clock
package stepper_pkg;
  localparam int CLK_MHZ = 40;
  localparam int RESET_HOLD_US = 20;
  localparam int RESET_HOLD_CYC = RESET_HOLD_US * CLK_MHZ;
  localparam int PULSE_MIN_US = 20;
  localparam int PULSE_MIN_CYC = PULSE_MIN_US * CLK_MHZ;
  localparam int STEP_FREQ_MAX_KHZ = 25;
  localparam logic [2:0] POS_RESET = 3'h0;
  localparam logic [2:0] POS_FULL_STEP = 3'h2;
  localparam logic [2:0] POS_HALF_STEP = 3'h1;
  // phase output order {winding1_fwd, winding2_fwd, winding1_rev, winding2_rev}
  localparam logic [3:0] PHASE_OFF = 4'h0;
  localparam logic [3:0] PHASE_AT_RESET = 4'h9;
endpackage : stepper_pkg

// [verification/step_host.sv]
// host model: reset, step clock and control levels
// assumes core_clk from the bench
`timescale 1ns/1ps
module step_host import stepper_pkg::*;
(
  input wire logic core_clk,
  output logic rst_n = 1'b0,
  output logic step_clk = 1'b0,
  output logic excitation_select = 1'b0,
  output logic direction_select = 1'b0
);
  task automatic drive(input logic rst, clk, mode, dir);
    rst_n = rst;
    step_clk = clk;
    excitation_select = mode;
    direction_select = dir;
    repeat (rst ? PULSE_MIN_CYC : RESET_HOLD_CYC) @(posedge core_clk);
    #2;
  endtask : drive
endmodule : step_host

// [verification/test_stepper_phase_sequencer.sv]
// self-checking bench for the phase sequencer
// assumes step_host drives every sequencer input except core_clk, which the bench generates
`timescale 1ns/1ps
module test_stepper_phase_sequencer import stepper_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst_n, step_clk, excitation_select, direction_select;
  wire logic [3:0] outs;
  logic [2:0] pos;
  int n_mismatch = 0, total_checks = 0, cycles = 0;
  localparam logic [3:0] PAT [8] = '{4'h9, 4'h8, 4'hC, 4'h4, 4'h6, 4'h2, 4'h3, 4'h1};
  always #12.5 core_clk = ~core_clk;
  step_host host (.core_clk(core_clk), .rst_n(rst_n), .step_clk(step_clk),
    .excitation_select(excitation_select), .direction_select(direction_select));
  stepper_phase_sequencer dut (.core_clk(core_clk), .rst_n(rst_n), .step_clk(step_clk),
    .excitation_select(excitation_select), .direction_select(direction_select),
    .first_coil_switch(outs[3]), .winding2_fwd(outs[2]), .winding1_rev(outs[1]),
    .winding2_rev(outs[0]));
  always @(posedge core_clk)
    if (++cycles == 40000) give_verdict(1);
  task automatic check(input logic [3:0] seen, exp);
    total_checks++;
    n_mismatch += (seen !== exp);
    if (seen !== exp)
      $display("[FAIL] %0t seen=%h exp=%h", $time, seen, exp);
  endtask : check
  task automatic give_verdict(input int extra);
    n_mismatch += extra;
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict
  task automatic reset_run;
    host.drive(1'b0, 1'b0, 1'b0, 1'b0);
    check(outs, PHASE_OFF);
    host.drive(1'b1, 1'b0, 1'b0, 1'b0);
    pos = POS_RESET;
    check(outs, PHASE_AT_RESET);
  endtask : reset_run
  task automatic step(input logic mode, dir);
    pos = pos + (dir ? 3'h7 : 3'h1) * ((mode || pos[0]) ? POS_HALF_STEP : POS_FULL_STEP);
    host.drive(1'b1, 1'b1, mode, dir);
    check(outs, PAT[pos]);
    host.drive(1'b1, 1'b0, mode, dir);
    check(outs, PAT[pos]);
  endtask : step
  task automatic full_fwd;
    repeat (5) step(1'b0, 1'b0);
  endtask : full_fwd
  task automatic half_rev;
    repeat (8) step(1'b1, 1'b1);
  endtask : half_rev
  task automatic mode_dir_swap;
    step(1'b1, 1'b0);
    step(1'b0, 1'b1);
    step(1'b0, 1'b1);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask : mode_dir_swap
  initial
  begin
    reset_run();
    full_fwd();
    half_rev();
    mode_dir_swap();
    step(1'b0, 1'b0);
    reset_run();
    give_verdict(0);
  end
endmodule : test_stepper_phase_sequencer
